//--- src/ddr_guard_pkg.sv
// Shared timing constants, command set and pin encodings for the DDR command guard
package ddr_guard_pkg;

  // System clock period in picoseconds (50 MHz)
  localparam int CLK_PERIOD_PS = 20000;
  // System clock cycles per memory clock CK (CK is clk divided by two)
  localparam int CK_DIV = 2;

  // Least time in ns to whole clk cycles, rounded up, never below one
  function automatic int min_cyc(input int t_ns);
    int c;
    c = (t_ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction

  // Device timing figures as printed
  localparam int TRCD_NS = 15;
  localparam int TRRD_NS = 10;
  localparam int TRFC_NS = 70;
  localparam int TMRD_NS = 10;
  localparam int TXSNR_NS = 75;
  localparam int TRAS_MIN_NS = 40;
  localparam int TRAS_MAX_NS = 70000;
  localparam int TRP_NS = 15;
  localparam int TRC_NS = 55;
  localparam int TWR_NS = 15;
  localparam real TREFI_US = 7.8;
  localparam int TWTR_CK = 2;
  localparam int TXSRD_CK = 200;
  localparam int TDLL_CK = 200;
  localparam int REF_MAX_OWED = 8;

  // Derived counts in clk cycles
  localparam int TRCD_CYC = min_cyc(TRCD_NS);
  localparam int TRRD_CYC = min_cyc(TRRD_NS);
  localparam int TRFC_CYC = min_cyc(TRFC_NS);
  localparam int TMRD_CYC = min_cyc(TMRD_NS);
  localparam int TXSNR_CYC = min_cyc(TXSNR_NS);
  localparam int TRAS_MIN_CYC = min_cyc(TRAS_MIN_NS);
  localparam int TRP_CYC = min_cyc(TRP_NS);
  localparam int TRC_CYC = min_cyc(TRC_NS);
  localparam int TWR_CYC = min_cyc(TWR_NS);
  // Longest times round down
  localparam int TRAS_MAX_CYC = (TRAS_MAX_NS * 1000) / CLK_PERIOD_PS;
  localparam int TREFI_CYC = $rtoi(TREFI_US * 1.0e6 / CLK_PERIOD_PS + 1.0e-6);
  localparam int TWTR_CYC = TWTR_CK * CK_DIV;
  localparam int TXSRD_CYC = TXSRD_CK * CK_DIV;
  localparam int TDLL_CYC = TDLL_CK * CK_DIV;
  // Forced close this many cycles before the open-row limit
  localparam int RAS_MAX_MARGIN = 16;

  // Address bit positions
  localparam int AP_BIT = 10;
  localparam int DLL_RST_BIT = 8;

  // Requested operations
  typedef enum logic [3:0] {
    OP_NOP, OP_ACT, OP_RD, OP_WR, OP_PRE, OP_REF, OP_MRS, OP_SRE, OP_SRX
  } ddr_op_t;

  // Pin codes {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] PIN_NOP = 4'h7;
  localparam logic [3:0] PIN_ACT = 4'h3;
  localparam logic [3:0] PIN_RD = 4'h5;
  localparam logic [3:0] PIN_WR = 4'h4;
  localparam logic [3:0] PIN_PRE = 4'h2;
  localparam logic [3:0] PIN_REF = 4'h1;
  localparam logic [3:0] PIN_MRS = 4'h0;

  // Operation to pin code; self refresh entry is a refresh with CKE low
  function automatic logic [3:0] pin_code(input ddr_op_t op);
    case (op)
      OP_ACT: return PIN_ACT;
      OP_RD: return PIN_RD;
      OP_WR: return PIN_WR;
      OP_PRE: return PIN_PRE;
      OP_REF, OP_SRE: return PIN_REF;
      OP_MRS: return PIN_MRS;
      default: return PIN_NOP;
    endcase
  endfunction

endpackage

//--- src/cycle_timer_bank.sv
// A bank of independent down-counting interval timers
`timescale 1ns/1ps
module cycle_timer_bank #(
  parameter int N = 8,
  parameter int W = 12
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [N-1:0] load,
  input wire logic [N*W-1:0] load_val,
  output logic [N-1:0] expired
);

  // One counter per lane, idle at zero
  logic [W-1:0] count_reg [N];

  genvar i;
  for (i = 0; i < N; i++) begin : g_lane
    // Expired while the lane has run down
    assign expired[i] = (count_reg[i] == '0);

    // Load wins over the count-down
    always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
        count_reg[i] <= '0;
      end else if (load[i]) begin
        count_reg[i] <= load_val[i*W +: W];
      end else if (count_reg[i] != '0) begin
        count_reg[i] <= count_reg[i] - 1'b1;
      end
    end
  end

endmodule // cycle_timer_bank

//--- src/ddr_cmd_timing_guard.sv
// Host-side command sequencer that spaces DDR commands to the device timing
`timescale 1ns/1ps
module ddr_cmd_timing_guard #(
  parameter int BL = 4,
  parameter int TRAS_MAX_CYC = ddr_guard_pkg::TRAS_MAX_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic cmd_valid,
  input wire ddr_guard_pkg::ddr_op_t cmd_op,
  input wire logic [1:0] cmd_bank,
  input wire logic [12:0] cmd_addr,
  input wire logic cmd_auto_pre,
  output logic cmd_done,
  output logic [3:0] ref_owed,
  output logic in_self_refresh,
  output logic ck_p,
  output logic ck_n,
  output logic cke,
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic [1:0] ba,
  output logic [12:0] addr
);

  // Burst and write-data spans in clk cycles (write latency one CK)
  localparam int BURST_CYC = (BL / 2) * ddr_guard_pkg::CK_DIV;
  localparam int WR_DATA_CYC = ddr_guard_pkg::CK_DIV + BURST_CYC;
  localparam int WTR_GAP_CYC = WR_DATA_CYC + ddr_guard_pkg::TWTR_CYC;
  localparam int OLD_ROW_CYC = TRAS_MAX_CYC - ddr_guard_pkg::RAS_MAX_MARGIN;
  // Timer lane indices
  localparam int T_RRD = 0;
  localparam int T_RFC = 1;
  localparam int T_MRD = 2;
  localparam int T_XSNR = 3;
  localparam int T_XSRD = 4;
  localparam int T_DLL = 5;
  localparam int T_WTR = 6;
  localparam int T_REFI = 7;

  // Larger of two counts
  function automatic logic [11:0] max12(input logic [11:0] a, input logic [11:0] b);
    return (a > b) ? a : b;
  endfunction

  // Lowest set bit of a bank vector
  function automatic logic [1:0] first_bank(input logic [3:0] v);
    return v[0] ? 2'h0 : v[1] ? 2'h1 : v[2] ? 2'h2 : 2'h3;
  endfunction

  // Clock divider and pin registers
  logic ck_reg, ck_n_reg, cke_reg;
  logic [3:0] pins_reg;
  logic [1:0] ba_reg;
  logic [12:0] addr_reg;
  logic done_reg, in_sr_reg;
  logic [3:0] owed_reg, owed_next;
  // Per-bank state: open flag and remaining delays
  logic [3:0] open_reg;
  logic [11:0] rcd_reg [4];
  logic [11:0] ras_reg [4];
  logic [11:0] rdy_reg [4];
  logic [11:0] age_reg [4];
  // Shared interval timers
  logic [7:0] tmr_load, tmr_exp;
  logic [95:0] tmr_val;

  // Per-bank flags
  logic [3:0] rcd_zero, ras_zero, rdy_zero, old_row;
  genvar g;
  for (g = 0; g < 4; g++) begin : g_flag
    assign rcd_zero[g] = (rcd_reg[g] == 12'h000);
    assign ras_zero[g] = (ras_reg[g] == 12'h000);
    assign rdy_zero[g] = (rdy_reg[g] == 12'h000);
    assign old_row[g] = open_reg[g] && (age_reg[g] >= 12'(OLD_ROW_CYC));
  end

  // Commands leave on the edge where CK falls, so the device samples mid-slot
  wire slot = ck_reg;
  wire all_closed = (open_reg == 4'h0);
  wire all_ready = (rdy_zero == 4'hF);
  wire common_ok = tmr_exp[T_MRD] && tmr_exp[T_XSNR] && !in_sr_reg;
  wire bank_open = open_reg[cmd_bank];
  wire quiet_ok = common_ok && all_closed && all_ready;
  wire urgent = (owed_reg >= 4'(ddr_guard_pkg::REF_MAX_OWED - 1));

  // Legality of the presented request
  wire act_ok = common_ok && !bank_open && rdy_zero[cmd_bank]
    && tmr_exp[T_RRD] && tmr_exp[T_RFC];
  wire rd_ok = common_ok && bank_open && rcd_zero[cmd_bank]
    && tmr_exp[T_WTR] && tmr_exp[T_XSRD] && tmr_exp[T_DLL];
  wire wr_ok = common_ok && bank_open && rcd_zero[cmd_bank];
  wire pre_ok = common_ok && bank_open && ras_zero[cmd_bank];
  wire ref_ok = quiet_ok && tmr_exp[T_RFC];
  wire user_legal =
    (cmd_op == ddr_guard_pkg::OP_ACT) ? act_ok :
    (cmd_op == ddr_guard_pkg::OP_RD) ? rd_ok :
    (cmd_op == ddr_guard_pkg::OP_WR) ? wr_ok :
    (cmd_op == ddr_guard_pkg::OP_PRE) ? pre_ok :
    (cmd_op == ddr_guard_pkg::OP_REF || cmd_op == ddr_guard_pkg::OP_SRE) ? ref_ok :
    (cmd_op == ddr_guard_pkg::OP_MRS) ? quiet_ok :
    (cmd_op == ddr_guard_pkg::OP_SRX) ? in_sr_reg : 1'b0;

  // Own closes for aged rows or a refresh backlog, then own refresh
  wire [3:0] want_pre = (old_row | (open_reg & {4{urgent}})) & ras_zero;
  wire force_pre = slot && (want_pre != 4'h0) && common_ok;
  wire force_ref = slot && !force_pre && urgent && ref_ok;
  // User blocked while a refresh is overdue or a row is aged out
  wire user_go = slot && !force_pre && !force_ref && !urgent && cmd_valid && user_legal;
  wire issue = force_pre || force_ref || user_go;
  wire ddr_guard_pkg::ddr_op_t sel_op = force_pre ? ddr_guard_pkg::OP_PRE :
    force_ref ? ddr_guard_pkg::OP_REF : cmd_op;
  wire [1:0] sel_bank = force_pre ? first_bank(want_pre) : cmd_bank;
  wire sel_ap = user_go && cmd_auto_pre &&
    (cmd_op == ddr_guard_pkg::OP_RD || cmd_op == ddr_guard_pkg::OP_WR);
  // Bit 10 is the close flag only for column and close commands; a row address keeps it
  wire [12:0] ap_mask = 13'h0001 << ddr_guard_pkg::AP_BIT;
  wire addr_flag = (cmd_op == ddr_guard_pkg::OP_RD) || (cmd_op == ddr_guard_pkg::OP_WR)
    || (cmd_op == ddr_guard_pkg::OP_PRE);
  wire [12:0] user_addr = sel_ap ? (cmd_addr | ap_mask) :
    addr_flag ? (cmd_addr & ~ap_mask) : cmd_addr;
  wire [12:0] sel_addr = user_go ? user_addr : 13'h0000;
  wire is_op_act = issue && (sel_op == ddr_guard_pkg::OP_ACT);
  wire is_op_rd = issue && (sel_op == ddr_guard_pkg::OP_RD);
  wire is_op_wr = issue && (sel_op == ddr_guard_pkg::OP_WR);
  wire is_op_ref = issue && (sel_op == ddr_guard_pkg::OP_REF);
  wire is_op_mrs = issue && (sel_op == ddr_guard_pkg::OP_MRS);
  wire is_op_srx = issue && (sel_op == ddr_guard_pkg::OP_SRX);
  wire dll_reset = is_op_mrs && (sel_bank == 2'h0) && sel_addr[ddr_guard_pkg::DLL_RST_BIT];

  // Idle time after a column command with auto close
  wire [11:0] ras_left = ras_reg[sel_bank];
  wire [11:0] ap_rd_wait = max12(12'(BURST_CYC), ras_left)
    + 12'(ddr_guard_pkg::TRP_CYC - 1);
  wire [11:0] ap_wr_wait = max12(12'(WR_DATA_CYC + ddr_guard_pkg::TWR_CYC), ras_left)
    + 12'(ddr_guard_pkg::TRP_CYC - 1);

  // Timer reloads; counts load one short so the spacing lands exactly
  assign tmr_val = {12'(ddr_guard_pkg::TREFI_CYC - 1), 12'(WTR_GAP_CYC - 1),
    12'(ddr_guard_pkg::TDLL_CYC - 1), 12'(ddr_guard_pkg::TXSRD_CYC - 1),
    12'(ddr_guard_pkg::TXSNR_CYC - 1), 12'(ddr_guard_pkg::TMRD_CYC - 1),
    12'(ddr_guard_pkg::TRFC_CYC - 1), 12'(ddr_guard_pkg::TRRD_CYC - 1)};
  assign tmr_load = {tmr_exp[T_REFI] || is_op_srx, is_op_wr, dll_reset, is_op_srx,
    is_op_srx, is_op_mrs, is_op_ref, is_op_act};

  cycle_timer_bank #(.N(8), .W(12)) u_timers (
    .clk(clk),
    .sys_rst(sys_rst),
    .load(tmr_load),
    .load_val(tmr_val),
    .expired(tmr_exp)
  );

  // Refresh debt: one per interval, one repaid per refresh, none in self refresh
  wire refi_tick = tmr_exp[T_REFI] && !in_sr_reg;
  assign owed_next = is_op_srx ? 4'h0 :
    (refi_tick && !is_op_ref && owed_reg != 4'(ddr_guard_pkg::REF_MAX_OWED)) ? owed_reg + 4'h1 :
    (!refi_tick && is_op_ref && owed_reg != 4'h0) ? owed_reg - 4'h1 : owed_reg;

  // Divider, pins and status; pins hold a whole CK period
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ck_reg <= 1'b0;
      ck_n_reg <= 1'b1;
      cke_reg <= 1'b1;
      pins_reg <= ddr_guard_pkg::PIN_NOP;
      ba_reg <= 2'h0;
      addr_reg <= 13'h0000;
      done_reg <= 1'b0;
      in_sr_reg <= 1'b0;
      owed_reg <= 4'h0;
    end else begin
      ck_reg <= ~ck_reg;
      ck_n_reg <= ck_reg;
      done_reg <= user_go;
      owed_reg <= owed_next;
      if (slot) begin
        pins_reg <= issue ? ddr_guard_pkg::pin_code(sel_op) : ddr_guard_pkg::PIN_NOP;
        ba_reg <= sel_bank;
        addr_reg <= sel_addr;
      end
      // Self refresh entry drops CKE, exit raises it with a NOP
      if (issue && sel_op == ddr_guard_pkg::OP_SRE) begin
        cke_reg <= 1'b0;
        in_sr_reg <= 1'b1;
      end else if (is_op_srx) begin
        cke_reg <= 1'b1;
        in_sr_reg <= 1'b0;
      end
    end
  end

  // Per-bank row state and delays
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      open_reg <= 4'h0;
      for (int b = 0; b < 4; b++) begin
        rcd_reg[b] <= 12'h000;
        ras_reg[b] <= 12'h000;
        rdy_reg[b] <= 12'h000;
        age_reg[b] <= 12'h000;
      end
    end else begin
      for (int b = 0; b < 4; b++) begin
        // Default: run down, and age the open row
        if (!rcd_zero[b]) rcd_reg[b] <= rcd_reg[b] - 12'h001;
        if (!ras_zero[b]) ras_reg[b] <= ras_reg[b] - 12'h001;
        if (!rdy_zero[b]) rdy_reg[b] <= rdy_reg[b] - 12'h001;
        if (open_reg[b]) age_reg[b] <= age_reg[b] + 12'h001;
        if (issue && sel_bank == 2'(b)) begin
          case (sel_op)
            ddr_guard_pkg::OP_ACT: begin
              open_reg[b] <= 1'b1;
              rcd_reg[b] <= 12'(ddr_guard_pkg::TRCD_CYC - 1);
              ras_reg[b] <= 12'(ddr_guard_pkg::TRAS_MIN_CYC - 1);
              rdy_reg[b] <= 12'(ddr_guard_pkg::TRC_CYC - 1);
              age_reg[b] <= 12'h000;
            end
            ddr_guard_pkg::OP_PRE: begin
              open_reg[b] <= 1'b0;
              rdy_reg[b] <= max12(rdy_reg[b], 12'(ddr_guard_pkg::TRP_CYC - 1));
            end
            ddr_guard_pkg::OP_RD: begin
              if (sel_ap) begin
                open_reg[b] <= 1'b0;
                rdy_reg[b] <= max12(rdy_reg[b], ap_rd_wait);
              end
            end
            ddr_guard_pkg::OP_WR: begin
              if (sel_ap) begin
                open_reg[b] <= 1'b0;
                rdy_reg[b] <= max12(rdy_reg[b], ap_wr_wait);
              end
            end
            default: begin
            end
          endcase
        end
      end
    end
  end

  assign cmd_done = done_reg;
  assign ref_owed = owed_reg;
  assign in_self_refresh = in_sr_reg;
  assign ck_p = ck_reg;
  assign ck_n = ck_n_reg;
  assign cke = cke_reg;
  assign {cs_n, ras_n, cas_n, we_n} = pins_reg;
  assign ba = ba_reg;
  assign addr = addr_reg;

  // Checking aids: clk cycles since each event, saturating
  logic [11:0] act_age [4];
  logic [11:0] any_act_age, ref_age, mrs_age, srx_age, wr_age, dll_age;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int b = 0; b < 4; b++) act_age[b] <= 12'hFFF;
      any_act_age <= 12'hFFF;
      ref_age <= 12'hFFF;
      mrs_age <= 12'hFFF;
      srx_age <= 12'hFFF;
      wr_age <= 12'hFFF;
      dll_age <= 12'hFFF;
    end else begin
      for (int b = 0; b < 4; b++)
        act_age[b] <= (is_op_act && sel_bank == 2'(b)) ? 12'h001 : act_age[b] + 12'(act_age[b] != 12'hFFF);
      any_act_age <= is_op_act ? 12'h001 : any_act_age + 12'(any_act_age != 12'hFFF);
      ref_age <= is_op_ref ? 12'h001 : ref_age + 12'(ref_age != 12'hFFF);
      mrs_age <= is_op_mrs ? 12'h001 : mrs_age + 12'(mrs_age != 12'hFFF);
      srx_age <= is_op_srx ? 12'h001 : srx_age + 12'(srx_age != 12'hFFF);
      wr_age <= is_op_wr ? 12'h001 : wr_age + 12'(wr_age != 12'hFFF);
      dll_age <= dll_reset ? 12'h001 : dll_age + 12'(dll_age != 12'hFFF);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_rcd;
    (is_op_rd || is_op_wr) |-> act_age[sel_bank] >= 12'(ddr_guard_pkg::TRCD_CYC);
  endproperty
  a_rcd: assert property (p_rcd)
    else $error("column command too soon after activate");
  property p_rrd;
    is_op_act |-> any_act_age >= 12'(ddr_guard_pkg::TRRD_CYC);
  endproperty
  a_rrd: assert property (p_rrd)
    else $error("activates too close together");
  property p_rfc;
    (is_op_act || is_op_ref) |-> ref_age >= 12'(ddr_guard_pkg::TRFC_CYC);
  endproperty
  a_rfc: assert property (p_rfc)
    else $error("command too soon after refresh");
  property p_wtr;
    is_op_rd |-> wr_age >= 12'(WTR_GAP_CYC);
  endproperty
  a_wtr: assert property (p_wtr)
    else $error("read too soon after write data");
  property p_mrd;
    issue |-> mrs_age >= 12'(ddr_guard_pkg::TMRD_CYC);
  endproperty
  a_mrd: assert property (p_mrd)
    else $error("command too soon after mode write");
  property p_refi;
    (urgent && !in_sr_reg) |-> ##[1:1000] is_op_ref;
  endproperty
  a_refi: assert property (p_refi)
    else $error("overdue refresh not issued");
  property p_xsrd;
    is_op_rd |-> srx_age >= 12'(ddr_guard_pkg::TXSRD_CYC);
  endproperty
  a_xsrd: assert property (p_xsrd)
    else $error("read too soon after self refresh exit");
  property p_xsnr;
    (issue && !is_op_rd) |-> srx_age >= 12'(ddr_guard_pkg::TXSNR_CYC);
  endproperty
  a_xsnr: assert property (p_xsnr)
    else $error("command too soon after self refresh exit");
  property p_ap;
    (is_op_wr && sel_ap) |=> rdy_reg[$past(sel_bank)] >= 12'(WR_DATA_CYC + 1);
  endproperty
  a_ap: assert property (p_ap)
    else $error("write auto close idle time too short");
  property p_ras;
    (issue && sel_op == ddr_guard_pkg::OP_PRE) |-> act_age[sel_bank] >= 12'(ddr_guard_pkg::TRAS_MIN_CYC);
  endproperty
  a_ras: assert property (p_ras)
    else $error("row closed before least open time");
  property p_owed;
    owed_reg <= 4'(ddr_guard_pkg::REF_MAX_OWED);
  endproperty
  a_owed: assert property (p_owed)
    else $error("too many refreshes outstanding");
  property p_dll;
    is_op_rd |-> dll_age >= 12'(ddr_guard_pkg::TDLL_CYC);
  endproperty
  a_dll: assert property (p_dll)
    else $error("read before loop lock time");

endmodule // ddr_cmd_timing_guard

//--- tb/ddr_device_model.sv
// Behavioural DDR device that flags short command spacing at its pins
`timescale 1ns/1ps
module ddr_device_model #(
  parameter real TCK_NS = 40.0,
  parameter int BL = 4
) (
  input wire logic ck_p,
  input wire logic cke,
  input wire logic [3:0] code,
  input wire logic [1:0] ba,
  input wire logic [12:0] addr,
  output int viol_count
);
  // Event times in ns; far past means nothing to wait for
  realtime act_t[4] = '{4{-1.0e6}};
  realtime free_t[4] = '{4{-1.0e6}};
  realtime last_act = -1.0e6, ref_t = -1.0e6, mrs_t = -1.0e6, srx_t = -1.0e6;
  realtime dll_t = -1.0e6, wr_end = -1.0e6, ref_due = 7800.0, now, t_end;
  logic open_b[4] = '{4{1'b0}};
  logic in_sr = 1'b0;
  int owed = 0;
  initial viol_count = 0;

  // Count a fault and name the short spacing
  task automatic flag(input string what);
    viol_count++;
    $display("wrong value %s expected met seen short at %0t", what, $realtime);
  endtask

  // Pins are sampled on each CK rise
  always @(posedge ck_p) begin
    now = $realtime;
    if (in_sr) begin
      // Exit leaves no refresh debt
      if (cke) begin
        in_sr = 1'b0;
        srx_t = now;
        owed = 0;
        ref_due = now + 7800.0;
      end
    end else begin
      while (now >= ref_due) begin
        owed++;
        ref_due += 7800.0;
      end
      if (owed > 8) flag("refresh debt");
      if (code != 4'h7 && now - mrs_t < 10.0) flag("mode set gap");
      if (code != 4'h7 && code != 4'h5 && now - srx_t < 75.0) flag("exit gap");
      case (code)
        ddr_guard_pkg::PIN_ACT: begin
          if (open_b[ba] || now < free_t[ba] || now - act_t[ba] < 55.0) begin
            flag("bank busy");
          end
          if (now - last_act < 10.0) flag("activate gap");
          if (now - ref_t < 70.0) flag("refresh to activate");
          open_b[ba] = 1'b1;
          act_t[ba] = now;
          last_act = now;
        end
        ddr_guard_pkg::PIN_RD, ddr_guard_pkg::PIN_WR: begin
          if (!open_b[ba] || now - act_t[ba] < 15.0) flag("row to column");
          if (code == ddr_guard_pkg::PIN_RD) begin
            if (now - wr_end < 2 * TCK_NS) flag("write to read");
            if (now - srx_t < 200 * TCK_NS) flag("exit to read");
            if (now - dll_t < 200 * TCK_NS) flag("loop lock");
            t_end = now + BL / 2 * TCK_NS;
          end else begin
            wr_end = now + (1 + BL / 2) * TCK_NS;
            t_end = wr_end + 15.0;
          end
          // Auto close waits for burst end and least open time
          if (addr[10]) begin
            open_b[ba] = 1'b0;
            free_t[ba] = ((t_end > act_t[ba] + 40.0) ? t_end : act_t[ba] + 40.0) + 15.0;
          end
        end
        ddr_guard_pkg::PIN_PRE: begin
          if (open_b[ba] && (now - act_t[ba] < 40.0 || now - act_t[ba] > 70000.0)) begin
            flag("row open time");
          end
          open_b[ba] = 1'b0;
          free_t[ba] = now + 15.0;
        end
        ddr_guard_pkg::PIN_REF: begin
          if (now - ref_t < 70.0) flag("refresh gap");
          ref_t = now;
          in_sr = !cke;
          if (cke) owed--;
        end
        ddr_guard_pkg::PIN_MRS: begin
          mrs_t = now;
          if (ba == 2'h0 && addr[8]) dll_t = now;
        end
        default: ;
      endcase
    end
  end
endmodule // ddr_device_model

//--- tb/tb.sv
// Self-checking bench for the DDR command guard against a device model
`timescale 1ns/1ps
module tb;
  // One request and the least clk spacing from an earlier row
  typedef struct {
    ddr_guard_pkg::ddr_op_t op;
    logic [1:0] bank;
    logic [12:0] addr;
    int since;
    int gap;
  } row_t;
  localparam int AGE = 600; // Short open-row limit keeps the aged case brief
  logic clk, sys_rst, cmd_valid, cmd_auto_pre, cmd_done, in_self_refresh;
  logic ck_p, ck_n, cke, cs_n, ras_n, cas_n, we_n;
  logic [1:0] cmd_bank, ba;
  logic [12:0] cmd_addr, addr;
  logic [3:0] ref_owed;
  ddr_guard_pkg::ddr_op_t cmd_op;
  row_t rows[$];
  int done_at[32];
  int failures = 0, total_checks = 0, cycles = 0, viol_count, t0;

  ddr_cmd_timing_guard #(.BL(4), .TRAS_MAX_CYC(AGE)) u_ddr_cmd_timing_guard (
    .clk(clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_bank(cmd_bank), .cmd_addr(cmd_addr), .cmd_auto_pre(cmd_auto_pre),
    .cmd_done(cmd_done), .ref_owed(ref_owed), .in_self_refresh(in_self_refresh),
    .ck_p(ck_p), .ck_n(ck_n), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
    .we_n(we_n), .ba(ba), .addr(addr));
  ddr_device_model u_ddr_device_model (.ck_p(ck_p), .cke(cke),
    .code({cs_n, ras_n, cas_n, we_n}), .ba(ba), .addr(addr), .viol_count(viol_count));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Verdict and end of run
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic check_ge(input string name, input int lim, input int got);
    total_checks++;
    if (got < lim) begin
      failures++;
      $display("wrong value %s expected at least %0d seen %0d", name, lim, got);
    end
  endtask

  // Expected pin code of each operation
  function automatic logic [3:0] want(input ddr_guard_pkg::ddr_op_t op);
    case (op)
      ddr_guard_pkg::OP_ACT: return ddr_guard_pkg::PIN_ACT;
      ddr_guard_pkg::OP_RD: return ddr_guard_pkg::PIN_RD;
      ddr_guard_pkg::OP_WR: return ddr_guard_pkg::PIN_WR;
      ddr_guard_pkg::OP_PRE: return ddr_guard_pkg::PIN_PRE;
      ddr_guard_pkg::OP_MRS: return ddr_guard_pkg::PIN_MRS;
      ddr_guard_pkg::OP_REF, ddr_guard_pkg::OP_SRE: return ddr_guard_pkg::PIN_REF;
      default: return ddr_guard_pkg::PIN_NOP;
    endcase
  endfunction

  task automatic add(input ddr_guard_pkg::ddr_op_t op, input logic [1:0] b,
      input logic [12:0] a, input int since, input int gap);
    rows.push_back(row_t'{op, b, a, since, gap});
  endtask

  task automatic reset_check();
    check("ck pair", 16'h0001, {14'h0000, ck_p, ck_n});
    check("cke", 16'h0001, {15'h0000, cke});
    check("pins", {12'h000, ddr_guard_pkg::PIN_NOP}, {12'h000, cs_n, ras_n, cas_n, we_n});
    check("idle outputs", 16'h0000, {8'h00, cmd_done, in_self_refresh, ba, ref_owed});
  endtask

  // Entered just after an edge; address bit 10 asks for auto close
  task automatic issue(input int i);
    int n;
    ddr_guard_pkg::ddr_op_t op;
    n = 0;
    op = rows[i].op;
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_bank = rows[i].bank;
    cmd_addr = rows[i].addr;
    cmd_auto_pre = rows[i].addr[10];
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (cmd_done !== 1'b1 && n < 1000);
    done_at[i] = cycles;
    check("issue pulse", 16'h0001, {15'h0000, cmd_done});
    check("pins", {12'h000, want(op)}, {12'h000, cs_n, ras_n, cas_n, we_n});
    check("cke", {15'h0000, op != ddr_guard_pkg::OP_SRE}, {15'h0000, cke});
    if (op inside {ddr_guard_pkg::OP_ACT, ddr_guard_pkg::OP_RD, ddr_guard_pkg::OP_WR,
        ddr_guard_pkg::OP_MRS}) begin
      check("bank and addr", {1'b0, rows[i].bank, rows[i].addr}, {1'b0, ba, addr});
    end
    if (op == ddr_guard_pkg::OP_PRE) begin
      check("single close", {13'h0000, rows[i].bank, 1'b0}, {13'h0000, ba, addr[10]});
    end
    if (op inside {ddr_guard_pkg::OP_SRE, ddr_guard_pkg::OP_SRX}) begin
      check("self refresh", {15'h0000, op == ddr_guard_pkg::OP_SRE}, {15'h0000, in_self_refresh});
    end
    if (rows[i].since >= 0) check_ge("gap", rows[i].gap, cycles - done_at[rows[i].since]);
    #1;
  endtask

  // Wait for an own command of the guard on the pins
  task automatic await_code(input logic [3:0] code, input int lim);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while ({cs_n, ras_n, cas_n, we_n} !== code && n < lim);
    check("own command", {12'h000, code}, {12'h000, cs_n, ras_n, cas_n, we_n});
  endtask

  // Debt ceiling sampled mid-cycle, clear of the edge that updates it
  always @(negedge clk) begin
    if (!sys_rst) check("owed ceiling", 16'h0001, {15'h0000, ref_owed <= 4'h8});
  end

  // Cycle count and hang limit
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      failures++;
      $display("wrong value run length expected below 8000 seen %0d", cycles);
      complete_run();
    end
  end

  initial begin
    sys_rst = 1'b1;
    cmd_valid = 1'b0;
    cmd_op = ddr_guard_pkg::OP_NOP;
    cmd_bank = 2'h0;
    cmd_addr = 13'h0000;
    cmd_auto_pre = 1'b0;
    add(ddr_guard_pkg::OP_ACT, 2'h0, 13'h0123, -1, 0);
    add(ddr_guard_pkg::OP_ACT, 2'h1, 13'h1abc, 0, 1);
    add(ddr_guard_pkg::OP_WR, 2'h0, 13'h0010, 0, 1);
    add(ddr_guard_pkg::OP_RD, 2'h0, 13'h0020, 2, 10);
    add(ddr_guard_pkg::OP_PRE, 2'h0, 13'h0000, 0, 2);
    add(ddr_guard_pkg::OP_PRE, 2'h1, 13'h0000, 1, 2);
    add(ddr_guard_pkg::OP_MRS, 2'h0, 13'h0100, 5, 1);
    add(ddr_guard_pkg::OP_ACT, 2'h2, 13'h0f0f, 6, 1);
    add(ddr_guard_pkg::OP_RD, 2'h2, 13'h0004, 6, 400);
    add(ddr_guard_pkg::OP_WR, 2'h2, 13'h0440, 8, 1);
    add(ddr_guard_pkg::OP_ACT, 2'h2, 13'h0055, 9, 8);
    add(ddr_guard_pkg::OP_RD, 2'h2, 13'h0480, 10, 1);
    add(ddr_guard_pkg::OP_REF, 2'h0, 13'h0000, 11, 5);
    add(ddr_guard_pkg::OP_REF, 2'h0, 13'h0000, 12, 4);
    add(ddr_guard_pkg::OP_ACT, 2'h3, 13'h1fff, 13, 4);
    add(ddr_guard_pkg::OP_PRE, 2'h3, 13'h0000, 14, 2);
    add(ddr_guard_pkg::OP_SRE, 2'h0, 13'h0000, 15, 1);
    add(ddr_guard_pkg::OP_SRX, 2'h0, 13'h0000, 16, 1);
    add(ddr_guard_pkg::OP_ACT, 2'h0, 13'h0aaa, 17, 4);
    add(ddr_guard_pkg::OP_RD, 2'h0, 13'h0408, 17, 400);
    add(ddr_guard_pkg::OP_ACT, 2'h1, 13'h0777, -1, 0);
    repeat (20) @(posedge clk);
    #1;
    reset_check();
    #1;
    sys_rst = 1'b0;
    for (int i = 0; i < 20; i++) issue(i);
    // Read of a closed bank is held off
    cmd_op = ddr_guard_pkg::OP_RD;
    cmd_bank = 2'h1;
    cmd_auto_pre = 1'b0;
    repeat (40) begin
      @(posedge clk);
      #1;
      check("held request", 16'h0000, {15'h0000, cmd_done});
    end
    #1;
    // Row left open is closed by the guard before its limit
    issue(20);
    cmd_valid = 1'b0;
    t0 = done_at[20];
    await_code(ddr_guard_pkg::PIN_PRE, 1000);
    check("forced close", 16'h0001, {13'h0000, cmd_done, ba});
    check_ge("open row limit", 0, AGE - (cycles - t0));
    // Idle until the debt forces a refresh
    await_code(ddr_guard_pkg::PIN_REF, 4000);
    check("forced refresh", 16'h0001, {15'h0000, ref_owed inside {4'h6, 4'h7}});
    #1;
    sys_rst = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    reset_check();
    #1;
    sys_rst = 1'b0;
    @(posedge clk);
    #1;
    check("ck after release", 16'h0001, {15'h0000, ck_p});
    check("device faults", 16'h0000, viol_count[15:0]);
    complete_run();
  end
endmodule // tb
